/* File: rtl/cprx_receiver_end.sv */
// repeater receiver end: decryption, downstream auth control, forwarding
// assumes up to three transmitter ends on the shared link interface
`timescale 1ns/10ps
module cprx_receiver_end
	import cprx_pkg::*;
#(
	parameter int NUM_TX = 3, // at most three transmitters per receiver
	parameter logic [`CP_LFSR_W-1:0] KEY_SEED = 32'h5a3c9617,
	parameter logic [`CP_DEV_W-1:0] TX_ADDR0 = 7'h18,
	parameter logic [`CP_DEV_W-1:0] TX_ADDR1 = 7'h19,
	parameter logic [`CP_DEV_W-1:0] TX_ADDR2 = 7'h1a,
	parameter logic [`CP_DEV_W-1:0] ALIAS0 = 7'h28,
	parameter logic [`CP_DEV_W-1:0] ALIAS1 = 7'h29,
	parameter logic [`CP_DEV_W-1:0] ALIAS2 = 7'h2a
) (
	cprx_link_if.rx_end link,
	// configuration straps
	input wire logic repeater_mode,
	input wire logic dual_link_cfg,
	input wire logic [NUM_TX-1:0] tx_present,
	input wire logic local_display,
	// incoming protected stream from the serial link
	input wire logic protect_active,
	input wire logic in_de,
	input wire logic [`CP_PIX_W-1:0] in_pix,
	input wire logic in_aud_valid,
	input wire logic [`CP_AUD_W-1:0] in_aud,
	input wire logic ser_aud_frame_mode,
	input wire logic aud_mode_override,
	input wire logic aud_mode_force_frame,
	// upstream control channel: forwarding requests
	input wire logic fwd_req,
	input wire logic fwd_wr,
	input wire logic [`CP_DEV_W-1:0] fwd_dev,
	input wire logic [`CP_REG_W-1:0] fwd_reg,
	input wire logic [7:0] fwd_wdata,
	output logic fwd_busy,
	output logic fwd_done,
	output logic [`CP_RDATA_W-1:0] fwd_rdata,
	// upstream control channel: vector list delivery
	output logic auth_complete,
	output logic list_valid,
	output logic [`CP_CNT_W-1:0] list_index,
	output logic [`CP_RDATA_W-1:0] list_data,
	input wire logic list_ready,
	// image enhancement enables
	output logic dither_enable,
	output logic white_bal_enable
);
	rx_state_t state;
	logic [NUM_TX-1:0] irq_meta, irq_sync;
	logic [NUM_TX-1:0] pending;
	logic just_read;
	logic [NUM_TX-1:0] done_tx;
	logic [`CP_TX_IDX_W-1:0] cur;
	logic [`CP_CNT_W-1:0] ds_count, ds_pos, total, send_pos;
	logic [`CP_RDATA_W-1:0] ack_data;
	logic any_ack;
	logic sent;
	logic [`CP_LFSR_W-1:0] lfsr;
	logic aud_frame;
	logic [`CP_DEV_W-1:0] fwd_target;
	ksv_t ksv_list [`CP_LIST_DEPTH];

	// device address of transmitter n
	function automatic logic [`CP_DEV_W-1:0] tx_addr(input logic [`CP_TX_IDX_W-1:0] n);
		case (n)
			2'd0: tx_addr = TX_ADDR0;
			2'd1: tx_addr = TX_ADDR1;
			default: tx_addr = TX_ADDR2;
		endcase
	endfunction

	// alias address translated to the real duplicate address
	assign fwd_target = (fwd_dev == ALIAS0) ? TX_ADDR0 :
		(fwd_dev == ALIAS1) ? TX_ADDR1 :
		(fwd_dev == ALIAS2) ? TX_ADDR2 : fwd_dev;

	// irq lines come from another chip, two flops first
	always_ff @(posedge link.clk_sys or negedge link.reset_n) begin
		if (!link.reset_n) begin
			irq_meta <= '1;
			irq_sync <= '1;
		end else begin
			irq_meta <= link.irq_level[NUM_TX-1:0];
			irq_sync <= irq_meta;
		end
	end

	// collect answers from whichever transmitter acknowledged
	always_comb begin
		ack_data = '0;
		any_ack = 1'b0;
		for (int i = 0; i < NUM_TX; i++) begin
			if (link.ack[i]) begin
				ack_data = link.rdata[i];
				any_ack = 1'b1;
			end
		end
	end

	// pending status reads; the synced line shows the stale low level for one edge
	// after a read, so that edge is masked; a line still low re-arms after it
	always_ff @(posedge link.clk_sys or negedge link.reset_n) begin
		if (!link.reset_n) begin
			pending <= '0;
			just_read <= 1'b0;
		end else begin
			just_read <= state == st_status && any_ack;
			for (int i = 0; i < NUM_TX; i++)
				if (state == st_status && any_ack && cur == i[1:0])
					pending[i] <= 1'b0;
				else if (repeater_mode && tx_present[i] && !irq_sync[i] && !just_read)
					pending[i] <= 1'b1;
		end
	end

	// downstream authentication sequencer
	always_ff @(posedge link.clk_sys or negedge link.reset_n) begin
		if (!link.reset_n) begin
			state <= st_idle;
			cur <= '0;
			ds_count <= '0;
			ds_pos <= '0;
			total <= '0;
			done_tx <= '0;
			fwd_done <= 1'b0;
			fwd_rdata <= '0;
		end else begin
			fwd_done <= 1'b0;
			case (state)
				st_idle: begin
					if (|pending) begin
						// the lowest pending transmitter is served first
						for (int i = NUM_TX - 1; i >= 0; i--)
							if (pending[i])
								cur <= i[1:0];
						state <= st_status;
						done_tx <= '0;
						total <= '0;
					end else if (fwd_req) begin
						state <= st_forward;
					end
				end
				st_forward: if (any_ack) begin
					fwd_rdata <= ack_data;
					fwd_done <= 1'b1;
					state <= st_idle;
				end
				st_status: if (!tx_present[cur] || any_ack)
					state <= (tx_present[cur] && ack_data[`CP_ST_AUTH_OK]) ? st_ksv : st_next;
				st_ksv: if (any_ack) begin
					ksv_list[total[2:0]] <= ack_data;
					total <= total + 4'd1;
					state <= st_count;
				end
				st_count: if (any_ack) begin
					ds_count <= ack_data[`CP_CNT_W-1:0];
					ds_pos <= '0;
					state <= (ack_data[`CP_CNT_W-1:0] == '0) ? st_next : st_list;
				end
				st_list: if (any_ack) begin
					if (total < `CP_LIST_DEPTH) begin
						ksv_list[total[2:0]] <= ack_data;
						total <= total + 4'd1;
					end
					ds_pos <= ds_pos + 4'd1;
					if (ds_pos + 4'd1 == ds_count)
						state <= st_next;
				end
				st_next: begin
					done_tx[cur] <= 1'b1;
					if (cur == 2'(NUM_TX - 1))
						state <= st_report;
					else begin
						cur <= cur + 2'd1;
						state <= st_status;
					end
				end
				st_report: if (sent)
					state <= |pending ? st_idle : st_report;
				default: state <= st_idle;
			endcase
		end
	end

	// one request at a time, held until its answer arrives
	always_comb begin
		link.req = 1'b0;
		link.wr = 1'b0;
		link.dev_addr = tx_addr(cur);
		link.wdata = fwd_wdata;
		case (state)
			st_status: link.reg_addr = `CP_REG_STATUS;
			st_ksv: link.reg_addr = `CP_REG_KSV;
			st_count: link.reg_addr = `CP_REG_COUNT;
			st_list: link.reg_addr = `CP_REG_LIST | 8'(ds_pos);
			default: link.reg_addr = fwd_reg;
		endcase
		if (state == st_forward) begin
			link.req = !any_ack;
			link.wr = fwd_wr;
			link.dev_addr = fwd_target;
		end else if (state inside {st_status, st_ksv, st_count, st_list})
			link.req = !any_ack && tx_present[cur];
	end
	assign fwd_busy = state != st_idle && state != st_forward && state != st_report;

	// upstream list delivery, complete only after every transmitter
	always_ff @(posedge link.clk_sys or negedge link.reset_n) begin
		if (!link.reset_n) begin
			send_pos <= '0;
			sent <= 1'b0;
			auth_complete <= 1'b0;
		end else if (state != st_report) begin
			send_pos <= '0;
			sent <= 1'b0;
			auth_complete <= 1'b0;
		end else if (!sent && list_ready && list_valid) begin
			send_pos <= send_pos + 4'd1;
			if (send_pos + 4'd1 == total) begin
				sent <= 1'b1;
				auth_complete <= &(done_tx | ~tx_present);
			end
		end else if (!sent && total == '0) begin
			sent <= 1'b1;
			auth_complete <= &(done_tx | ~tx_present);
		end
	end
	assign list_valid = state == st_report && !sent && total != '0;
	assign list_index = send_pos;
	assign list_data = ksv_list[send_pos[2:0]];

	// audio transport follows the serializer unless overridden
	assign aud_frame = aud_mode_override ? aud_mode_force_frame : ser_aud_frame_mode;

	// keystream from the internal seed, never brought to a port
	always_ff @(posedge link.clk_sys or negedge link.reset_n) begin
		if (!link.reset_n)
			lfsr <= 32'h00000001;
		else if (!protect_active)
			lfsr <= KEY_SEED;
		else if (in_de || in_aud_valid)
			lfsr <= {lfsr[30:0], ^(lfsr & `CP_LFSR_TAPS)};
	end

	// clear video, control and audio toward the transmitters
	always_ff @(posedge link.clk_sys or negedge link.reset_n) begin
		if (!link.reset_n) begin
			link.pix_data <= '0;
			link.pix_de <= 1'b0;
			link.aud_valid <= 1'b0;
			link.aud_data <= '0;
			link.aud_frame_mode <= 1'b0;
			link.protect_on <= 1'b0;
			link.dual_link <= 1'b0;
		end else begin
			link.pix_de <= in_de;
			link.aud_valid <= in_aud_valid;
			link.aud_frame_mode <= aud_frame;
			link.protect_on <= protect_active;
			link.dual_link <= dual_link_cfg;
			link.pix_data <= protect_active ? in_pix ^ lfsr[23:0] : in_pix;
			if (protect_active && !aud_frame)
				link.aud_data <= in_aud ^ lfsr;
			else
				link.aud_data <= in_aud;
		end
	end

	// enhancement would block encrypted audio and authentication
	assign dither_enable = !(repeater_mode && local_display);
	assign white_bal_enable = !(repeater_mode && local_display);
endmodule // cprx_receiver_end

/* File: shared/cprx_defines.svh */
// constants shared by the repeater receiver and transmitter ends
// assumes one 50 MHz clock (clk_sys) and active-low async reset_n
//
// Functional notes
// - receiver decrypts protected content with cipher
// - authentication runs over the embedded control channel
// - device keys internal, never reachable outside
// - two repeater levels, three transmitters each
// - transparent register forwarding with alias addresses
// - receiver drives auth, assembles and delivers list
// - receiver masters transmitters, reads status and vectors
// - transmitter authenticates downstream, exposes status
// - video output carries clear video, control, audio
// - receiver outputs clear, transmitter re-encrypts
// - local display: dithering and white balance off
// - four or eight pairs, same width everywhere
// - each node has a unique strapped address
// - all nodes put into repeater mode
// - irq line active low, pulled up
// - direct audio wiring optional, default embedded
// - island audio decrypted along with video
// - frame transport audio passes unencrypted
// - audio transport mode loaded from serializer
`ifndef CPRX_DEFINES_SVH
`define CPRX_DEFINES_SVH
`define CP_MAX_TX 3
`define CP_TX_IDX_W 2
`define CP_DEV_W 7
`define CP_REG_W 8
`define CP_RDATA_W 40
`define CP_LIST_DEPTH 8
`define CP_CNT_W 4
// transmitter register map
`define CP_REG_STATUS 8'h00
`define CP_REG_KSV 8'h01
`define CP_REG_COUNT 8'h02
`define CP_REG_LIST 8'h10
// status field positions
`define CP_ST_AUTH_OK 0
`define CP_ST_CHANGED 1
// keystream generator width and taps, pixel and audio widths
`define CP_LFSR_W 32
`define CP_LFSR_TAPS 32'h80200003
`define CP_PIX_W 24
`define CP_AUD_W 32
`endif

/* File: shared/cprx_pkg.sv */
// types shared by both ends of the repeater link
// assumes cprx_defines.svh is on the include path
`include "cprx_defines.svh"
package cprx_pkg;
	typedef enum logic {
		aud_island,
		aud_frame
	} audio_mode_t;
	typedef enum {
		st_idle,
		st_status,
		st_ksv,
		st_count,
		st_list,
		st_next,
		st_forward,
		st_report
	} rx_state_t;
	typedef logic [`CP_RDATA_W-1:0] ksv_t;
endpackage

/* File: shared/cprx_link_if.sv */
// link between the repeater receiver and up to three transmitters
// register channel, per-transmitter irq lines and the clear video stream
`timescale 1ns/10ps
`include "cprx_defines.svh"
interface cprx_link_if (
	input wire logic clk_sys,
	input wire logic reset_n
);
	// register channel, receiver is master
	logic req;
	logic wr;
	logic [`CP_DEV_W-1:0] dev_addr;
	logic [`CP_REG_W-1:0] reg_addr;
	logic [7:0] wdata;
	logic [`CP_MAX_TX-1:0] ack;
	logic [`CP_RDATA_W-1:0] rdata [`CP_MAX_TX];
	// open-drain irq, one per transmitter, level from pull-up
	logic [`CP_MAX_TX-1:0] irq_oe;
	logic [`CP_MAX_TX-1:0] irq_level;
	assign irq_level = ~irq_oe;
	// clear video, control and packetized audio
	logic [`CP_PIX_W-1:0] pix_data;
	logic pix_de;
	logic aud_valid;
	logic [`CP_AUD_W-1:0] aud_data;
	logic aud_frame_mode;
	logic dual_link;
	logic protect_on;
	modport rx_end (
		input clk_sys, reset_n, ack, rdata, irq_level,
		output req, wr, dev_addr, reg_addr, wdata,
		output pix_data, pix_de, aud_valid, aud_data, aud_frame_mode, dual_link, protect_on
	);
	modport tx_end (
		input clk_sys, reset_n, req, wr, dev_addr, reg_addr, wdata, irq_level,
		output ack, rdata, irq_oe,
		input pix_data, pix_de, aud_valid, aud_data, aud_frame_mode, dual_link, protect_on
	);
endinterface

/* File: rtl/cprx_transmitter_end.sv */
// repeater transmitter end: register target, irq driver and re-encryption
// assumes the receiver end masters the register channel of the link
`timescale 1ns/10ps
module cprx_transmitter_end
	import cprx_pkg::*;
#(
	parameter int IDX = 0,
	parameter logic [`CP_LFSR_W-1:0] KEY_SEED = 32'h1b2c3d4e
) (
	cprx_link_if.tx_end link,
	// straps
	input wire logic [`CP_DEV_W-1:0] address_strap_pin,
	input wire logic repeater_mode,
	input wire logic dual_link_cfg,
	// downstream authentication results
	input wire logic auth_ok,
	input wire ksv_t own_ksv,
	input wire logic list_we,
	input wire logic [`CP_CNT_W-1:0] list_idx,
	input wire ksv_t list_data,
	input wire logic [`CP_CNT_W-1:0] list_count,
	// re-encrypted stream downstream
	output logic [`CP_PIX_W-1:0] enc_pix,
	output logic enc_de,
	output logic [`CP_AUD_W-1:0] enc_aud,
	output logic enc_aud_valid,
	output logic width_mismatch
);
	ksv_t list_mem [`CP_LIST_DEPTH];
	logic auth_prev;
	logic changed;
	logic hit;
	logic [`CP_LFSR_W-1:0] lfsr;

	// target selected by its own strapped address
	assign hit = link.req && repeater_mode && (link.dev_addr == address_strap_pin);

	// list kept as seen downstream
	always_ff @(posedge link.clk_sys) begin
		if (list_we)
			list_mem[list_idx[2:0]] <= list_data;
	end

	// sticky change flag, set beats clear by the status read
	always_ff @(posedge link.clk_sys or negedge link.reset_n) begin
		if (!link.reset_n) begin
			auth_prev <= 1'b0;
			changed <= 1'b0;
		end else begin
			auth_prev <= auth_ok;
			if (auth_ok != auth_prev)
				changed <= 1'b1;
			else if (hit && !link.wr && link.reg_addr == `CP_REG_STATUS)
				changed <= 1'b0;
		end
	end
	assign link.irq_oe[IDX] = changed; // pulls the line low

	// register answers, one cycle after the request
	always_ff @(posedge link.clk_sys or negedge link.reset_n) begin
		if (!link.reset_n) begin
			link.ack[IDX] <= 1'b0;
			link.rdata[IDX] <= '0;
		end else begin
			link.ack[IDX] <= hit;
			if (hit) begin
				case (link.reg_addr)
					`CP_REG_STATUS: link.rdata[IDX] <= ksv_t'({changed, auth_ok});
					`CP_REG_KSV: link.rdata[IDX] <= own_ksv;
					`CP_REG_COUNT: link.rdata[IDX] <= ksv_t'(list_count);
					default: begin
						if (link.reg_addr[7:4] == 4'h1)
							link.rdata[IDX] <= list_mem[link.reg_addr[2:0]];
						else
							link.rdata[IDX] <= '0;
					end
				endcase
			end
		end
	end

	// keystream advances on every active pixel or audio word while protect_on is set, and reloads the seed otherwise
	always_ff @(posedge link.clk_sys or negedge link.reset_n) begin
		if (!link.reset_n)
			lfsr <= 32'h00000001;
		else if (!link.protect_on)
			lfsr <= KEY_SEED;
		else if (link.pix_de || link.aud_valid)
			lfsr <= {lfsr[30:0], ^(lfsr & `CP_LFSR_TAPS)};
	end

	// re-encrypt clear stream; frame transport audio stays clear
	always_ff @(posedge link.clk_sys or negedge link.reset_n) begin
		if (!link.reset_n) begin
			enc_pix <= '0;
			enc_de <= 1'b0;
			enc_aud <= '0;
			enc_aud_valid <= 1'b0;
		end else begin
			enc_de <= link.pix_de;
			enc_aud_valid <= link.aud_valid;
			enc_pix <= link.protect_on ? link.pix_data ^ lfsr[23:0] : link.pix_data;
			if (link.protect_on && !link.aud_frame_mode)
				enc_aud <= link.aud_data ^ lfsr;
			else
				enc_aud <= link.aud_data;
		end
	end

	// same link width needed on both sides
	assign width_mismatch = link.dual_link != dual_link_cfg;
endmodule // cprx_transmitter_end

/* File: verif/cprx_link_asserts.sv */
// checker for the register channel and irq lines of the repeater link
// assumes it sits beside cprx_link_if with the link signals as inputs
`timescale 1ns/10ps
`include "cprx_defines.svh"
module cprx_link_asserts #(
	parameter logic [`CP_DEV_W-1:0] TX_ADDR0 = 7'h18,
	parameter logic [`CP_DEV_W-1:0] ALIAS0 = 7'h28,
	parameter logic [`CP_DEV_W-1:0] ALIAS1 = 7'h29,
	parameter logic [`CP_DEV_W-1:0] ALIAS2 = 7'h2a
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// register channel
	input wire logic req,
	input wire logic [`CP_DEV_W-1:0] dev_addr,
	input wire logic [`CP_REG_W-1:0] reg_addr,
	input wire logic [`CP_MAX_TX-1:0] ack,
	// irq levels, high when idle
	input wire logic [`CP_MAX_TX-1:0] irq_level
);
	// one domain, so one clock and reset for every property
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// a unique strap means at most one answer
	property p_ack_onehot;
		$onehot0(ack);
	endproperty
	a_ack_onehot: assert property (p_ack_onehot)
		else $error("two transmitters answered at once");
	// an answer needs a request at the edge before
	property p_ack_cause;
		|ack |-> $past(req);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("answer without a request");
	// request drops in the answer cycle
	property p_req_drop;
		|ack |-> !req;
	endproperty
	a_req_drop: assert property (p_req_drop)
		else $error("request still up during its answer");
	// answers are single pulses
	property p_ack_pulse;
		|ack |=> ack == '0;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("answer lasted more than a cycle");
	// pending request holds its address steady
	property p_req_hold;
		req && ack == '0 |=> (|ack) || (req && $stable(dev_addr) && $stable(reg_addr));
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("request changed before its answer");
	// aliases are translated before they reach the link
	property p_no_alias;
		req |-> dev_addr != ALIAS0 && dev_addr != ALIAS1 && dev_addr != ALIAS2;
	endproperty
	a_no_alias: assert property (p_no_alias)
		else $error("alias address seen on the link");
	// irq from the first transmitter leads to its status read
	property p_irq_read;
		$fell(irq_level[0]) |-> ##[1:300] (req && reg_addr == 8'h00 && dev_addr == TX_ADDR0);
	endproperty
	a_irq_read: assert property (p_irq_read)
		else $error("irq not followed by a status read");
	// a status read releases the irq line
	property p_irq_clear;
		req && reg_addr == 8'h00 && dev_addr == TX_ADDR0 ##1 ack[0] |-> ##[0:1] irq_level[0];
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("irq line still low after status read");
endmodule // cprx_link_asserts

/* File: verif/content_protection_repeater_rx_tb.sv */
// testbench: receiver end facing three transmitter ends on one link
// assumes package, defines, link interface and both ends compiled first
`timescale 1ns/10ps
`include "cprx_defines.svh"
module content_protection_repeater_rx_tb import cprx_pkg::*;;
	localparam logic [31:0] RX_SEED = 32'h5a3c9617;
	localparam logic [6:0] ALIAS [3] = '{7'h28, 7'h29, 7'h2a};
	localparam logic [6:0] TXA [3] = '{7'h18, 7'h19, 7'h1a};
	// clock, reset and counters
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	int error_cnt = 0;
	int compares = 0;
	int cycles = 0;
	// receiver side
	logic rep_mode = 1'b1, dual_cfg = 1'b0, local_disp = 1'b0, protect = 1'b0, in_de = 1'b0;
	logic in_aud_valid = 1'b0, ser_frame = 1'b0, ovr = 1'b0, force_frame = 1'b0;
	logic [23:0] in_pix = '0;
	logic [31:0] in_aud = '0;
	logic fwd_req = 1'b0, fwd_busy, fwd_done, auth_complete, list_valid, list_ready = 1'b0;
	logic [6:0] fwd_dev = '0;
	logic [7:0] fwd_reg = '0;
	logic [3:0] list_index;
	logic [39:0] fwd_rdata, list_data;
	logic dither_enable, white_bal_enable;
	// transmitter side
	logic [2:0] auth_ok = '0, list_we = '0, tx_rep = '1, tx_dual = '0;
	logic [2:0] enc_de, enc_aud_valid, width_mismatch;
	logic [3:0] lst_idx = '0, lst_cnt = '0;
	ksv_t lst_data = '0;
	ksv_t own_ksv [3] = '{40'h11_2233_4455, 40'h66_7788_99aa, 40'hbb_ccdd_eeff};
	logic [23:0] enc_pix [3];
	logic [31:0] enc_aud [3];

	always #10 clk_sys = ~clk_sys;

	cprx_link_if link (.clk_sys(clk_sys), .reset_n(reset_n));
	cprx_receiver_end #(.KEY_SEED(RX_SEED)) i_cprx_receiver_end (
		.link(link), .repeater_mode(rep_mode), .dual_link_cfg(dual_cfg),
		.tx_present(3'b111), .local_display(local_disp), .protect_active(protect),
		.in_de(in_de), .in_pix(in_pix), .in_aud_valid(in_aud_valid), .in_aud(in_aud),
		.ser_aud_frame_mode(ser_frame), .aud_mode_override(ovr),
		.aud_mode_force_frame(force_frame), .fwd_req(fwd_req), .fwd_wr(1'b0),
		.fwd_dev(fwd_dev), .fwd_reg(fwd_reg), .fwd_wdata(8'h00), .fwd_busy(fwd_busy),
		.fwd_done(fwd_done), .fwd_rdata(fwd_rdata), .auth_complete(auth_complete),
		.list_valid(list_valid), .list_index(list_index), .list_data(list_data),
		.list_ready(list_ready), .dither_enable(dither_enable),
		.white_bal_enable(white_bal_enable));
	// first transmitter shares the receiver seed so its output round-trips
	for (genvar g = 0; g < 3; g++) begin : g_tx
		cprx_transmitter_end #(.IDX(g), .KEY_SEED(g == 0 ? RX_SEED : 32'h0f1e2d3c))
		i_cprx_transmitter_end (
			.link(link), .address_strap_pin(TXA[g]), .repeater_mode(tx_rep[g]),
			.dual_link_cfg(tx_dual[g]), .auth_ok(auth_ok[g]), .own_ksv(own_ksv[g]),
			.list_we(list_we[g]), .list_idx(lst_idx), .list_data(lst_data),
			.list_count(lst_cnt), .enc_pix(enc_pix[g]), .enc_de(enc_de[g]),
			.enc_aud(enc_aud[g]), .enc_aud_valid(enc_aud_valid[g]),
			.width_mismatch(width_mismatch[g]));
	end
	cprx_link_asserts i_cprx_link_asserts (
		.clk_sys(clk_sys), .reset_n(reset_n), .req(link.req), .dev_addr(link.dev_addr),
		.reg_addr(link.reg_addr), .ack(link.ack), .irq_level(link.irq_level));

	task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic do_reset();
		reset_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		reset_n = 1'b1;
		@(negedge clk_sys);
	endtask

	task automatic t_cfg();
		local_disp = 1'b1;
		dual_cfg = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk("dither_enable", dither_enable, 1'b0);
		chk("white_bal_enable", white_bal_enable, 1'b0);
		chk("width_mismatch", width_mismatch[0], 1'b1);
		tx_dual = '1;
		@(negedge clk_sys);
		chk("width_match", width_mismatch, 3'b000);
		$display("test cfg done");
	endtask

	task automatic t_stream(input logic frame);
		logic [23:0] hp [$];
		logic [31:0] ha [$];
		ser_frame = frame;
		protect = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk("aud_frame_mode", link.aud_frame_mode, frame);
		for (int i = 0; i < 10; i++) begin
			if (i >= 2) begin
				chk("enc_pix", enc_pix[0], hp[i - 2]);
				chk("enc_aud", enc_aud[0], ha[i - 2]);
				chk("link_de", link.pix_de, 1'b1);
				chk("enc_valid", {enc_de[0], enc_aud_valid[0]}, 2'b11);
			end
			if (i >= 1 && frame === 1'b1)
				chk("clear_aud", link.aud_data, ha[i - 1]);
			in_de = 1'b1;
			in_aud_valid = 1'b1;
			in_pix = 24'h3c5a00 + 24'(i);
			in_aud = 32'h9e370000 + 32'(i);
			hp.push_back(in_pix);
			ha.push_back(in_aud);
			@(negedge clk_sys);
		end
		in_de = 1'b0;
		in_aud_valid = 1'b0;
		ovr = 1'b1;
		force_frame = ~frame;
		repeat (2) @(negedge clk_sys);
		chk("aud_override", link.aud_frame_mode, !frame);
		protect = 1'b0;
		ovr = 1'b0;
		$display("test stream done");
	endtask

	task automatic fwd_read(input logic [6:0] dev, output logic done, output logic [39:0] data);
		int n;
		n = 0;
		fwd_dev = dev;
		fwd_reg = `CP_REG_KSV;
		fwd_req = 1'b1;
		do begin
			@(negedge clk_sys);
			n++;
		end while (fwd_done !== 1'b1 && n < 30);
		done = fwd_done;
		data = fwd_rdata;
		fwd_req = 1'b0;
		@(negedge clk_sys);
	endtask

	task automatic t_fwd();
		logic done;
		logic [39:0] data;
		for (int g = 0; g < 3; g++) begin
			fwd_read(ALIAS[g], done, data);
			chk("fwd_done", done, 1'b1);
			chk("fwd_rdata", data, own_ksv[g]);
		end
		// target out of repeater mode never answers, so reset clears the hang
		tx_rep[2] = 1'b0;
		fwd_read(ALIAS[2], done, data);
		chk("refused_done", done, 1'b0);
		tx_rep[2] = 1'b1;
		do_reset();
		$display("test forward done");
	endtask

	task automatic t_auth();
		ksv_t got [$];
		ksv_t want [3];
		int n;
		logic hit;
		n = 0;
		want = '{own_ksv[0], 40'h77_0000_0000, 40'h77_0000_0001};
		for (int i = 0; i < 2; i++) begin
			lst_idx = 4'(i);
			lst_data = want[i + 1];
			list_we = 3'b001;
			@(negedge clk_sys);
		end
		list_we = '0;
		lst_cnt = 4'h2;
		auth_ok = 3'b001;
		repeat (6) @(negedge clk_sys);
		chk("fwd_busy", fwd_busy, 1'b1);
		while (list_valid !== 1'b1 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		chk("early_complete", auth_complete, 1'b0);
		repeat (3) @(negedge clk_sys);
		chk("stall_valid", list_valid, 1'b1);
		chk("stall_index", list_index, 4'h0);
		list_ready = 1'b1;
		while (list_valid === 1'b1 && n < 400) begin
			got.push_back(list_data);
			@(negedge clk_sys);
			n++;
		end
		list_ready = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk("auth_complete", auth_complete, 1'b1);
		chk("list_len", 40'(got.size()), 40'd3);
		foreach (want[i]) begin
			hit = 1'b0;
			foreach (got[j])
				if (got[j] === want[i])
					hit = 1'b1;
			chk("list_entry", hit, 1'b1);
		end
		chk("irq_idle", link.irq_level, 3'b111);
		$display("test auth done");
	endtask

	// watchdog against a hung handshake
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			error_cnt++;
			wrap_up();
		end
	end

	// main sequence
	initial begin
		do_reset();
		t_cfg();
		t_stream(1'b0);
		t_stream(1'b1);
		t_fwd();
		t_auth();
		wrap_up();
	end
endmodule // content_protection_repeater_rx_tb
